// >>> logic/ssms_pkg.sv
// What this block does
// - Detection off: skip measuring, assume standstill
// - Detection keeps all phase outputs floating
// - UW lagging UV is forward, leading reverse
// - Speed from time between comparator rising edges
// - No comparator toggle before timeout: stationary
// - Forward spin found: load state, closed loop
// - Reverse drive accelerates through zero, then forward
// - Too fast in reverse: coast, measure again
// - Brake turns on all three low sides
// - Brake only if time field nonzero; timed
// - After brake, start as from standstill
// - Brake disabled: skip to standstill start
// - Align drives V to W, timed, set current
// - Nonzero pulse current limit selects position detect
// - Pulse pairs VW WV UV VU WU UW, release on threshold
// - Shortest pulse time marks rotor position
// - Release mode 0 recirculates, 1 floats
// - Start drive at selected advance angle
// - Open loop: set current, rising rate, ignore rotor
// - Handoff threshold spans 0.8 to 204.8 Hz
// - Accelerate, closed loop above handoff rate
// - Reverse drive if enabled, else brake decision
// - Direction change stops drive, restarts sequence
package ssms_pkg;
  // Register offsets
  localparam logic [3:0] OFS_WORD_A = 4'h0;
  localparam logic [3:0] OFS_WORD_B = 4'h1;
  localparam logic [3:0] OFS_WORD_C = 4'h2;
  localparam logic [3:0] OFS_WORD_D = 4'h3;
  localparam logic [3:0] OFS_WORD_E = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  // Reset values: every start feature off
  localparam logic [7:0] RST_WORD_A = 8'h00;
  localparam logic [7:0] RST_WORD_B = 8'h00;
  localparam logic [7:0] RST_WORD_C = 8'h00;
  localparam logic [7:0] RST_WORD_D = 8'h00;
  localparam logic [7:0] RST_WORD_E = 8'h00;
  // Field positions (low bit of each field)
  localparam int POS_OLC = 0;   // word A [1:0] open_loop_current_sel
  localparam int POS_RAMP = 2;  // word A [4:2] open_loop_ramp_rate
  localparam int POS_ALIGN = 5; // word A [7:5] align_duration_sel
  localparam int POS_ACC1 = 0;  // word B [2:0] first_order_accel
  localparam int POS_ACC2 = 3;  // word B [5:3] second_order_accel
  localparam int POS_ADV = 6;   // word B [7:6] post_detect_advance_angle
  localparam int POS_HOFF = 0;  // word C [4:0] handoff_threshold
  localparam int POS_BRK = 5;   // word C [7:5] brake_time_sel
  localparam int POS_SDEN = 0;  // word D [0] speed_detect_enable
  localparam int POS_RVEN = 1;  // word D [1] reverse_drive_enable
  localparam int POS_STO = 2;   // word D [3:2] stationary_timeout_sel
  localparam int POS_RVL = 4;   // word D [5:4] reverse_drive_speed_limit
  localparam int POS_PRATE = 6; // word D [7:6] position_pulse_rate
  localparam int POS_PLIM = 0;  // word E [3:0] position_pulse_current_limit
  localparam int POS_RELM = 4;  // word E [4] pulse_release_mode
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int ALIGN_BASE_MS = 40;
  localparam int BRAKE_STEP_MS = 100;
  localparam int ISD_TO_BASE_MS = 100;
  localparam int RVS_LIM_BASE_MS = 10;
  localparam int GAP_BASE_MS = 2;
  localparam int PULSE_CAP_MS = 8;
  localparam int MS_PER_S = 1000;
  // Rates in milli-deci-hertz; a commutation step per STEP_UNIT
  localparam int HOFF_BASE_DHZ = 8;
  localparam int MDHZ_PER_DHZ = 1000;
  localparam int STEP_UNIT = 10_000_000;
  localparam int RESYNC_NUM = 20_000_000;
  localparam int ACC1_BASE = 3;
  localparam int ACC2_BASE = 2;
  // Sequencer states
  typedef enum logic [3:0] {
    SSMS_PWR = 4'h0,
    SSMS_ISD = 4'h1,
    SSMS_BRAKE = 4'h2,
    SSMS_ALIGN = 4'h3,
    SSMS_PULSE = 4'h4,
    SSMS_REL = 4'h5,
    SSMS_RVS = 4'h6,
    SSMS_ACCEL = 4'h7,
    SSMS_CLOSED = 4'h8
  } ssms_state_e;
endpackage : ssms_pkg

// >>> logic/ssms_sequencer.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module ssms_sequencer #(
  parameter int TICK_CYC = ssms_pkg::TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic dir_in,
  input wire logic cmp_uv,
  input wire logic cmp_uw,
  input wire logic cur_over,
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo,
  output logic [1:0] drive_amp,
  output logic [2:0] comm_step,
  output logic closed_loop,
  output logic [15:0] resync_period
);
  import ssms_pkg::*;

  // The tick counter is 16 bits wide and needs at least two states
  if (TICK_CYC < 2 || TICK_CYC > 65535)
  begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_q; // Reset release shift
  logic rst_i_n;          // Internal reset

  // Assert asynchronously, release after two edges
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_i_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: 0 uv, 1 uw, 2 current, 3 direction
  logic [3:0] pin_raw;
  logic [3:0] s1_q, s2_q, s3_q;
  logic [3:0] filt_q;      // Accepted levels
  logic [3:0] filt_prev_q; // For edge detection

  assign pin_raw = {dir_in, cur_over, cmp_uw, cmp_uv};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      // Level accepted only once stages two and three agree
      always_ff @(posedge mclk or negedge rst_i_n)
      begin
        if (!rst_i_n)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
          filt_prev_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            filt_q[gi] <= s3_q[gi];
          filt_prev_q[gi] <= filt_q[gi];
        end
      end
    end
  endgenerate

  logic uv_rise, uw_rise, any_tog, dir_chg, cur_hit;
  assign uv_rise = filt_q[0] & ~filt_prev_q[0];
  assign uw_rise = filt_q[1] & ~filt_prev_q[1];
  assign any_tog = |(filt_q[1:0] ^ filt_prev_q[1:0]);
  assign dir_chg = filt_q[3] ^ filt_prev_q[3];
  assign cur_hit = filt_q[2];

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick; all long waits count these
  logic [15:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));

  always_ff @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
      tick_cnt_q <= 16'h0000;
    else if (tick)
      tick_cnt_q <= 16'h0000;
    else
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] word_a_q, word_b_q, word_c_q, word_d_q, word_e_q;
  ssms_state_e state_q, state_d;
  logic [2:0] best_q;   // Position found by pulses
  logic rev_seen_q;     // Last measurement started reverse drive

  // Writes land at once; the sequencer only sees snapshots
  always_ff @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      word_a_q <= RST_WORD_A;
      word_b_q <= RST_WORD_B;
      word_c_q <= RST_WORD_C;
      word_d_q <= RST_WORD_D;
      word_e_q <= RST_WORD_E;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_WORD_A: word_a_q <= reg_wdata;
        OFS_WORD_B: word_b_q <= reg_wdata;
        OFS_WORD_C: word_c_q <= reg_wdata;
        OFS_WORD_D: word_d_q <= reg_wdata;
        OFS_WORD_E: word_e_q <= reg_wdata;
        default: ; // Unmapped writes ignored
      endcase
    end
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        OFS_WORD_A: reg_rdata <= word_a_q;
        OFS_WORD_B: reg_rdata <= word_b_q;
        OFS_WORD_C: reg_rdata <= word_c_q;
        OFS_WORD_D: reg_rdata <= word_d_q;
        OFS_WORD_E: reg_rdata <= word_e_q;
        OFS_STATUS: reg_rdata <= {rev_seen_q, best_q, state_q};
        default: reg_rdata <= 8'h00; // Unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration snapshot, taken on entry to the power-on state so the
  // first decision made there already sees the fresh words
  logic [7:0] cfg_a_q, cfg_b_q, cfg_c_q, cfg_d_q, cfg_e_q;

  always_ff @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      cfg_a_q <= RST_WORD_A;
      cfg_b_q <= RST_WORD_B;
      cfg_c_q <= RST_WORD_C;
      cfg_d_q <= RST_WORD_D;
      cfg_e_q <= RST_WORD_E;
    end
    else if (state_d == SSMS_PWR)
    begin
      cfg_a_q <= word_a_q;
      cfg_b_q <= word_b_q;
      cfg_c_q <= word_c_q;
      cfg_d_q <= word_d_q;
      cfg_e_q <= word_e_q;
    end
  end

  // Decoded limits: times in milliseconds, handoff and acceleration in milli-deci-hertz
  logic [15:0] align_ms, brake_ms, isd_to_ms, rvs_lim_ms, gap_ms;
  logic [24:0] hoff_m, acc1_v, acc2_v;
  logic [2:0] brk_sel;
  logic [3:0] plim;
  assign brk_sel = cfg_c_q[POS_BRK +: 3];
  assign plim = cfg_e_q[POS_PLIM +: 4];
  assign align_ms = 16'(ALIGN_BASE_MS) << cfg_a_q[POS_ALIGN +: 3];
  assign brake_ms = 16'(BRAKE_STEP_MS * brk_sel);
  assign isd_to_ms = 16'(ISD_TO_BASE_MS) << cfg_d_q[POS_STO +: 2];
  assign rvs_lim_ms = 16'(RVS_LIM_BASE_MS) << cfg_d_q[POS_RVL +: 2];
  assign gap_ms = 16'(GAP_BASE_MS) << cfg_d_q[POS_PRATE +: 2];
  // 0.8 Hz at code 0 doubling every four codes to 204.8 Hz at 31
  assign hoff_m = 25'(HOFF_BASE_DHZ * MDHZ_PER_DHZ)
    << ((6'(cfg_c_q[POS_HOFF +: 5]) + 6'h01) >> 2);
  assign acc1_v = 25'(ACC1_BASE) << cfg_b_q[POS_ACC1 +: 3];
  assign acc2_v = 25'(ACC2_BASE) << cfg_b_q[POS_ACC2 +: 3];

  ////////////////////////////////////////////////////////////////////////
  // Initial speed measurement, counting only in the detect state
  logic [15:0] since_tog_q, since_rise_q, period_q;
  logic [1:0] rises_q;
  logic fwd_q, meas_evt_q;
  logic [2:0] spin_pos_q;

  // A measurement fires on each rising edge once two have been seen
  always_ff @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      since_tog_q <= 16'h0000;
      since_rise_q <= 16'h0000;
      period_q <= 16'h0000;
      rises_q <= 2'h0;
      fwd_q <= 1'b0;
      meas_evt_q <= 1'b0;
      spin_pos_q <= 3'h0;
    end
    else if (state_q != SSMS_ISD)
    begin
      since_tog_q <= 16'h0000;
      since_rise_q <= 16'h0000;
      rises_q <= 2'h0;
      meas_evt_q <= 1'b0;
    end
    else
    begin
      meas_evt_q <= 1'b0;
      if (any_tog)
        since_tog_q <= 16'h0000;
      else if (tick && since_tog_q != 16'hFFFF)
        since_tog_q <= since_tog_q + 16'h0001;
      if (uv_rise || uw_rise)
      begin
        period_q <= since_rise_q;
        since_rise_q <= 16'h0000;
        if (rises_q != 2'h2)
          rises_q <= rises_q + 2'h1;
        else
          meas_evt_q <= 1'b1;
      end
      else if (tick && since_rise_q != 16'hFFFF)
        since_rise_q <= since_rise_q + 16'h0001;
      if (uv_rise)
      begin
        // UW still low at UV rise means UW lags
        fwd_q <= ~filt_q[1];
        spin_pos_q <= filt_q[1] ? 3'h3 : 3'h0;
      end
    end
  end
  assign resync_period = period_q;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  logic [15:0] timer_q;      // Milliseconds in the current state
  logic [15:0] pulse_cyc_q;  // Clock cycles of the running pulse
  logic [2:0] pidx_q;        // Pulse pair index
  logic [24:0] freq_q, acc_q, phase_q;
  ssms_state_e brk_dec, init_dec;

  assign init_dec = (plim != 4'h0) ? SSMS_PULSE : SSMS_ALIGN;
  assign brk_dec = (brk_sel != 3'h0) ? SSMS_BRAKE : init_dec;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SSMS_PWR:
        // Hold until the current comparator lets go of the last drive, or
        // the first position pulse would end on a stale threshold hit
        if (!cur_hit)
          state_d = cfg_d_q[POS_SDEN] ? SSMS_ISD : brk_dec;
      SSMS_ISD:
        if (since_tog_q >= isd_to_ms)
          state_d = brk_dec;
        else if (meas_evt_q)
        begin
          if (fwd_q)
            state_d = SSMS_CLOSED;
          else if (period_q < rvs_lim_ms)
            state_d = SSMS_ISD;
          else if (cfg_d_q[POS_RVEN])
            state_d = SSMS_RVS;
          else
            state_d = brk_dec;
        end
      SSMS_BRAKE:
        if (timer_q >= brake_ms)
          state_d = init_dec;
      SSMS_ALIGN:
        if (timer_q >= align_ms)
          state_d = SSMS_ACCEL;
      SSMS_PULSE:
        if (cur_hit || timer_q >= 16'(PULSE_CAP_MS))
          state_d = SSMS_REL;
      SSMS_REL:
        if (timer_q >= gap_ms)
          state_d = (pidx_q == 3'h5) ? SSMS_ACCEL : SSMS_PULSE;
      SSMS_RVS:
        if (freq_q <= acc_q)
          state_d = SSMS_ACCEL;
      SSMS_ACCEL:
        if (freq_q > hoff_m)
          state_d = SSMS_CLOSED;
      SSMS_CLOSED:
        state_d = SSMS_CLOSED;
      default:
        state_d = SSMS_PWR;
    endcase
    if (dir_chg)
      state_d = SSMS_PWR;
  end

  // Pair tables as {high phase, low phase}; phases U=0 V=1 W=2
  function automatic logic [3:0] pulse_pair(input logic [2:0] i);
    case (i)
      3'h0: pulse_pair = 4'h6; // VW
      3'h1: pulse_pair = 4'h9; // WV
      3'h2: pulse_pair = 4'h1; // UV
      3'h3: pulse_pair = 4'h4; // VU
      3'h4: pulse_pair = 4'h8; // WU
      default: pulse_pair = 4'h2; // UW
    endcase
  endfunction : pulse_pair

  // Six-step order UV UW VW VU WU WV
  function automatic logic [3:0] step_pair(input logic [2:0] c);
    case (c)
      3'h0: step_pair = 4'h1;
      3'h1: step_pair = 4'h2;
      3'h2: step_pair = 4'h6;
      3'h3: step_pair = 4'h4;
      3'h4: step_pair = 4'h8;
      default: step_pair = 4'h9;
    endcase
  endfunction : step_pair

  // Pulse pair index to the matching six-step position
  function automatic logic [2:0] pulse_to_step(input logic [2:0] i);
    case (i)
      3'h0: pulse_to_step = 3'h2;
      3'h1: pulse_to_step = 3'h5;
      3'h2: pulse_to_step = 3'h0;
      3'h3: pulse_to_step = 3'h3;
      3'h4: pulse_to_step = 3'h4;
      default: pulse_to_step = 3'h1;
    endcase
  endfunction : pulse_to_step

  function automatic logic [2:0] step_add(input logic [2:0] a, input logic [2:0] b);
    logic [3:0] s;
    s = 4'(a) + 4'(b);
    step_add = (s >= 4'h6) ? 3'(s - 4'h6) : s[2:0];
  endfunction : step_add

  ////////////////////////////////////////////////////////////////////////
  // Sequencer datapath
  logic [15:0] best_cyc_q;
  logic [9:0] sec_q;
  logic [24:0] rvs_init;
  logic [31:0] rvs_div;
  assign rvs_div = 32'(RESYNC_NUM) / {16'h0000, period_q | 16'h0001};
  assign rvs_init = (rvs_div[31:25] != 7'h00) ? 25'h1FFFFFF : rvs_div[24:0];

  always_ff @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      state_q <= SSMS_PWR;
      timer_q <= 16'h0000;
      pulse_cyc_q <= 16'h0000;
      pidx_q <= 3'h0;
      best_q <= 3'h0;
      best_cyc_q <= 16'hFFFF;
      comm_step <= 3'h0;
      freq_q <= 25'h0;
      acc_q <= 25'h0;
      phase_q <= 25'h0;
      sec_q <= 10'h000;
      rev_seen_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q)
        timer_q <= 16'h0000;
      else if (tick && timer_q != 16'hFFFF)
        timer_q <= timer_q + 16'h0001;
      case (state_q)
        SSMS_PWR:
        begin
          pidx_q <= 3'h0;
          pulse_cyc_q <= 16'h0000; // A cut pulse must not bias the next run
          rev_seen_q <= 1'b0;
          best_cyc_q <= 16'hFFFF;
          freq_q <= 25'h0;
          acc_q <= acc1_v;
          phase_q <= 25'h0;
          sec_q <= 10'h000;
        end
        SSMS_ISD:
          if (state_d == SSMS_CLOSED)
            comm_step <= spin_pos_q;
          else if (state_d == SSMS_RVS)
          begin
            rev_seen_q <= 1'b1;
            comm_step <= spin_pos_q;
            freq_q <= rvs_init;
          end
        SSMS_ALIGN:
          // Leave align one step ahead, so the first open-loop vector pulls
          if (state_d == SSMS_ACCEL)
            comm_step <= step_add(3'h2, 3'h1);
          else
            comm_step <= 3'h2;
        SSMS_PULSE:
          if (state_d == SSMS_REL)
          begin
            pulse_cyc_q <= 16'h0000;
            if (pulse_cyc_q < best_cyc_q)
            begin
              best_cyc_q <= pulse_cyc_q;
              best_q <= pidx_q;
            end
          end
          else if (pulse_cyc_q != 16'hFFFF)
            pulse_cyc_q <= pulse_cyc_q + 16'h0001;
        SSMS_REL:
          if (state_d == SSMS_PULSE)
            pidx_q <= pidx_q + 3'h1;
          else if (state_d == SSMS_ACCEL)
            comm_step <= step_add(pulse_to_step(best_q),
              {1'b0, cfg_b_q[POS_ADV +: 2]});
        SSMS_RVS:
          // Field follows the reverse spin while slowing it
          if (state_d == SSMS_ACCEL)
            freq_q <= 25'h0;
          else if (tick)
          begin
            freq_q <= freq_q - acc_q;
            if (phase_q + freq_q >= 25'(STEP_UNIT))
            begin
              phase_q <= phase_q + freq_q - 25'(STEP_UNIT);
              comm_step <= step_add(comm_step, 3'h5);
            end
            else
              phase_q <= phase_q + freq_q;
          end
        SSMS_ACCEL:
          // Rate rises blindly; rotor position is not consulted
          if (tick && state_d == SSMS_ACCEL)
          begin
            freq_q <= freq_q + acc_q;
            sec_q <= (sec_q == 10'(MS_PER_S - 1)) ? 10'h000 : sec_q + 10'h001;
            if (sec_q == 10'(MS_PER_S - 1))
              acc_q <= acc_q + acc2_v;
            if (phase_q + freq_q >= 25'(STEP_UNIT))
            begin
              phase_q <= phase_q + freq_q - 25'(STEP_UNIT);
              comm_step <= step_add(comm_step, 3'h1);
            end
            else
              phase_q <= phase_q + freq_q;
          end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gate drive, registered so the power stage sees clean levels
  logic [3:0] pair_c;
  logic [2:0] hi_d, lo_d;
  logic [1:0] amp_d;

  always_comb
  begin
    pair_c = step_pair(comm_step);
    hi_d = 3'h0;
    lo_d = 3'h0;
    amp_d = 2'h0;
    case (state_q)
      SSMS_BRAKE:
        lo_d = 3'h7;
      SSMS_ALIGN:
      begin
        hi_d = 3'h2;
        lo_d = 3'h4;
        amp_d = cfg_a_q[POS_OLC +: 2];
      end
      SSMS_PULSE:
      begin
        pair_c = pulse_pair(pidx_q);
        hi_d = 3'h1 << pair_c[3:2];
        lo_d = 3'h1 << pair_c[1:0];
        amp_d = 2'h3;
      end
      SSMS_REL:
      begin
        // Mode 0 keeps the low side on so current recirculates
        pair_c = pulse_pair(pidx_q);
        lo_d = cfg_e_q[POS_RELM] ? 3'h0 : (3'h1 << pair_c[1:0]);
      end
      SSMS_RVS, SSMS_ACCEL, SSMS_CLOSED:
      begin
        hi_d = 3'h1 << pair_c[3:2];
        lo_d = 3'h1 << pair_c[1:0];
        amp_d = cfg_a_q[POS_OLC +: 2];
      end
      default: ; // Power-on and detection float all phases
    endcase
  end

  always_ff @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      gate_hi <= 3'h0;
      gate_lo <= 3'h0;
      drive_amp <= 2'h0;
      closed_loop <= 1'b0;
    end
    else
    begin
      gate_hi <= dir_chg ? 3'h0 : hi_d;
      gate_lo <= dir_chg ? 3'h0 : lo_d;
      drive_amp <= amp_d;
      closed_loop <= (state_q == SSMS_CLOSED);
    end
  end
endmodule : ssms_sequencer

// >>> sim/ssms_chk_sva.sv
`timescale 1ns/1ps
module ssms_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic dir_in,
  input wire logic cur_over,
  input wire logic [2:0] gate_hi,
  input wire logic [2:0] gate_lo,
  input wire logic [1:0] drive_amp,
  input wire logic [2:0] comm_step,
  input wire logic closed_loop
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Cycles since the direction pin moved, saturating so it cannot wrap
  logic [3:0] dir_age_q;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      dir_age_q <= 4'hF;
    else if ($changed(dir_in))
      dir_age_q <= 4'h0;
    else if (dir_age_q != 4'hF)
      dir_age_q <= dir_age_q + 4'h1;
  // Pin passes four flops and the gate register, so allow a few cycles for the drive to drop
  sequence s_drive_off;
    ##[1:8] (gate_hi == 3'h0 && gate_lo == 3'h0);
  endsequence
  ////////////////////////////////////////
  a_read_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_read: assert property ($past(reg_rd) && $past(reg_addr) > 4'h5 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_brake_low_sides: assert property (gate_lo == 3'h7 |-> gate_hi == 3'h0)
    else $error("high side on while braking");
  a_single_pair: assert property (gate_hi != 3'h0 |-> $onehot(gate_hi) && $onehot(gate_lo))
    else $error("more than one phase pair driven");
  a_limit_release: assert property ($rose(cur_over) && drive_amp == 2'h3 && gate_hi != 3'h0
    |-> ##[1:8] gate_hi == 3'h0)
    else $error("pulse not released at current limit");
  a_dir_stops_drive: assert property ($changed(dir_in) |-> s_drive_off)
    else $error("drive kept after direction change");
  a_dir_leaves_closed: assert property ($changed(dir_in) && closed_loop |-> ##[1:8] !closed_loop)
    else $error("closed loop kept after direction change");
  a_closed_needs_dir: assert property ($fell(closed_loop) |-> dir_age_q < 4'hA)
    else $error("closed loop left without direction change");
  a_closed_holds_step: assert property (closed_loop && $past(closed_loop) |-> $stable(comm_step))
    else $error("drive step moved in closed loop");
endmodule : ssms_chk
bind ssms_sequencer ssms_chk u_chk (.mclk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .dir_in,
  .cur_over, .gate_hi, .gate_lo, .drive_amp, .comm_step, .closed_loop);

// >>> sim/ssms_motor.sv
`timescale 1ns/1ps
module ssms_motor (
  input wire logic mclk,
  input wire logic [2:0] gate_hi,
  input wire logic [2:0] gate_lo,
  input wire logic [1:0] spin,
  output logic cmp_uv,
  output logic cmp_uw,
  output logic cur_over
);
  localparam int P = 240; // Electrical period of a coasting rotor in cycles
  int ph; // Rotor angle in cycles
  int cur; // Cycles the current has been building
  int sh; // Phase offset of the UW comparator
  always @(posedge mclk)
  begin
    ph <= (ph + 1) % P;
    cur <= (gate_hi != 3'h0) ? cur + 1 : 0;
  end
  // WU has the lowest inductance, so its current rises fastest
  assign cur_over = cur >= ((gate_hi == 3'h4 && gate_lo == 3'h1) ? 6 : 12);
  // Forward: UW trails UV by a sixth of a turn; reverse: it leads
  assign sh = (spin == 2'h1) ? P - P / 6 : P / 6;
  assign cmp_uv = (spin != 2'h0) && ph < P / 2;
  assign cmp_uw = (spin != 2'h0) && (ph + sh) % P < P / 2;
endmodule : ssms_motor

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ssms_pkg::*;
  localparam int TC = 20; // Short ms tick keeps timed states brief
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic dir_in = 1'b0;
  logic [1:0] spin = 2'h0;
  logic [7:0] reg_rdata, v;
  logic cmp_uv, cmp_uw, cur_over, closed_loop;
  logic [2:0] gate_hi, gate_lo, comm_step;
  logic [1:0] drive_amp;
  logic [15:0] resync_period;
  int bad_count = 0;
  int checks_done = 0;
  logic [5:0] pairs [6] = '{6'h14, 6'h22, 6'h0A, 6'h11, 6'h21, 6'h0C}; // {hi,lo} per pulse
  always #20 mclk = ~mclk;
  ssms_sequencer #(.TICK_CYC(TC)) DUT (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .dir_in, .cmp_uv, .cmp_uw, .cur_over, .gate_hi, .gate_lo, .drive_amp,
    .comm_step, .closed_loop, .resync_period);
  ssms_motor motor (.mclk, .gate_hi, .gate_lo, .spin, .cmp_uv, .cmp_uw, .cur_over);
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data is taken at the edge that closes its single valid cycle
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask : rd
  task automatic wait_gates(input logic [5:0] w, input int lim);
    int n;
    n = 0;
    while ({gate_hi, gate_lo} !== w && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    check(16'(n < lim), 16'h0001);
  endtask : wait_gates
  // Length of a pattern against k ticks, one tick of slack each way
  task automatic hold_ms(input logic [5:0] w, input int k);
    int n;
    n = 0;
    while ({gate_hi, gate_lo} === w && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    check(16'(n >= (k - 1) * TC && n <= (k + 1) * TC), 16'h0001);
  endtask : hold_ms
  task automatic wait_closed(input int lim);
    int n;
    n = 0;
    while (closed_loop !== 1'b1 && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    check(16'(closed_loop), 16'h0001);
  endtask : wait_closed
  task automatic restart;
    @(posedge mclk);
    dir_in <= ~dir_in;
    wait_gates(6'h00, 10);
  endtask : restart
  task automatic final_report;
    $display("%0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report;
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 6; i++)
    begin
      rd(i == 5 ? 4'hF : 4'(i));
      check(16'(v), 16'h0000);
    end
    rd(OFS_STATUS);
    check(16'(v[3:0]), 16'(SSMS_ALIGN));
    wr(OFS_WORD_A, 8'h02);
    wr(OFS_WORD_B, 8'h3F);
    wr(OFS_WORD_C, 8'h20);
    rd(OFS_WORD_A);
    check(16'(v), 16'h0002);
    check(16'(drive_amp), 16'h0000);
    $display("test registers done");
    restart;
    wait_gates(6'h07, 400);
    hold_ms(6'h07, 100);
    wait_gates(6'h14, 8);
    check(16'(drive_amp), 16'h0002);
    hold_ms(6'h14, 40);
    wait_closed(20000);
    $display("test brake done");
    wr(OFS_WORD_C, 8'h00);
    wr(OFS_WORD_D, 8'hC0);
    wr(OFS_WORD_E, 8'h05);
    restart;
    for (int i = 0; i < 6; i++)
    begin
      wait_gates(pairs[i], 2000);
      wait_gates({3'h0, pairs[i][2:0]}, 40);
    end
    repeat (400) @(posedge mclk);
    rd(OFS_STATUS);
    check(16'(v[6:4]), 16'h0004);
    wait_closed(20000);
    $display("test position detect done");
    wr(OFS_WORD_E, 8'h00);
    wr(OFS_WORD_D, 8'h01);
    spin <= 2'h1;
    restart;
    repeat (40) @(posedge mclk);
    check(16'({gate_hi, gate_lo}), 16'h0000);
    wait_closed(3000);
    check(16'(comm_step), 16'h0000);
    check(16'(resync_period >= 16'h0001 && resync_period <= 16'h000A), 16'h0001);
    rd(OFS_STATUS);
    check(16'(v[7]), 16'h0000);
    $display("test resync done");
    final_report;
  end
endmodule : testbench
